//--- design/rsi_pkg.sv
/*
 reset status and register init package: register map, per-register reset masks,
 own control register offsets and enumerations.
 assumes a 32-bit AXI4-Lite register bus with one register per aligned word.
*/
package rsi_pkg;
	// bank bases: byte address = bank base + 4 * printed index
	localparam logic [11:0] RSI_BANK_UART = 12'h000;
	localparam logic [11:0] RSI_BANK_SPI = 12'h100;
	localparam logic [11:0] RSI_BANK_RAM = 12'h200;
	localparam logic [11:0] RSI_BANK_OWN = 12'h300;
	// printed register indices
	localparam logic [5:0] RSI_OFS_UART_CONTROL_ONE = 6'h05;
	localparam logic [5:0] RSI_OFS_UART_CONTROL_TWO = 6'h06;
	localparam logic [5:0] RSI_OFS_UART_STATUS = 6'h07;
	localparam logic [5:0] RSI_OFS_UART_RECEIVE_BUFFER = 6'h08;
	localparam logic [5:0] RSI_OFS_UART_TRANSMIT_BUFFER = 6'h09;
	localparam logic [5:0] RSI_OFS_SERIAL_PERIPH_CONTROL_ONE = 6'h05;
	localparam logic [5:0] RSI_OFS_SERIAL_PERIPH_CONTROL_TWO = 6'h06;
	localparam logic [5:0] RSI_OFS_SERIAL_PERIPH_DATA = 6'h07;
	localparam logic [5:0] RSI_OFS_PULL_HIGH_CTRL_PORTS_6_8 = 6'h0A;
	localparam logic [5:0] RSI_OFS_PULL_LOW_CTRL_PORTS_6_8 = 6'h0B;
	localparam logic [5:0] RSI_OFS_PULL_HIGH_CTRL_PORT_7 = 6'h0C;
	localparam logic [5:0] RSI_OFS_PULL_LOW_CTRL_PORT_7 = 6'h0D;
	localparam logic [5:0] RSI_OFS_GENERAL_PURPOSE_RAM = 6'h10;
	localparam logic [5:0] RSI_RAM_LAST = 6'h3F;
	localparam int RSI_RAM_DEPTH = 48;
	// own registers in the own bank
	localparam logic [5:0] RSI_OFS_CTRL = 6'h00;
	localparam logic [5:0] RSI_OFS_STAT = 6'h01;
	localparam logic [5:0] RSI_OFS_IRQ_STATUS = 6'h02;
	localparam logic [5:0] RSI_OFS_IRQ_CLEAR = 6'h03;
	localparam logic [5:0] RSI_OFS_IRQ_ENABLE = 6'h04;
	// bank register slots
	localparam int RSI_NREG = 12;
	localparam int RSI_SLOT_UART_CONTROL_ONE = 0;
	localparam int RSI_SLOT_UART_RECEIVE_BUFFER = 3;
	localparam int RSI_SLOT_SERIAL_PERIPH_CONTROL_TWO = 6;
	localparam logic [11:0] RSI_REG_BANK [RSI_NREG] = '{RSI_BANK_UART, RSI_BANK_UART,
		RSI_BANK_UART, RSI_BANK_UART, RSI_BANK_UART, RSI_BANK_SPI, RSI_BANK_SPI,
		RSI_BANK_SPI, RSI_BANK_SPI, RSI_BANK_SPI, RSI_BANK_SPI, RSI_BANK_SPI};
	localparam logic [5:0] RSI_REG_OFS [RSI_NREG] = '{RSI_OFS_UART_CONTROL_ONE,
		RSI_OFS_UART_CONTROL_TWO, RSI_OFS_UART_STATUS, RSI_OFS_UART_RECEIVE_BUFFER,
		RSI_OFS_UART_TRANSMIT_BUFFER, RSI_OFS_SERIAL_PERIPH_CONTROL_ONE,
		RSI_OFS_SERIAL_PERIPH_CONTROL_TWO, RSI_OFS_SERIAL_PERIPH_DATA,
		RSI_OFS_PULL_HIGH_CTRL_PORTS_6_8, RSI_OFS_PULL_LOW_CTRL_PORTS_6_8,
		RSI_OFS_PULL_HIGH_CTRL_PORT_7, RSI_OFS_PULL_LOW_CTRL_PORT_7};
	// implemented bits; unused bits read zero
	localparam logic [7:0] RSI_IMP [RSI_NREG] = '{8'hFF, 8'h38, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
		8'h87, 8'hFF, 8'h3F, 8'h3F, 8'h0F, 8'h0F};
	// software-writable bits; receive buffer is read-only
	localparam logic [7:0] RSI_WR [RSI_NREG] = '{8'hFF, 8'h38, 8'hFF, 8'h00, 8'hFF, 8'hFF,
		8'h87, 8'hFF, 8'h3F, 8'h3F, 8'h0F, 8'h0F};
	// power-on values
	localparam logic [7:0] RSI_POR [RSI_NREG] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h3F, 8'h3F, 8'h0F, 8'h0F};
	// pin or watchdog reset: bits kept, bits set
	localparam logic [7:0] RSI_RST_KEEP [RSI_NREG] = '{8'hFC, 8'hFF, 8'hE0, 8'hFF, 8'hFF,
		8'hFE, 8'h06, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
	localparam logic [7:0] RSI_RST_SET [RSI_NREG] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h3F, 8'h3F, 8'h0F, 8'h0F};
	// wake-up clears: on any wake, and on wake from sleep only
	localparam logic [7:0] RSI_WAKE_CLR [RSI_NREG] = '{8'h01, 8'h00, 8'h01, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	localparam logic [7:0] RSI_SLEEP_CLR [RSI_NREG] = '{8'h40, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	// decoded targets beyond the bank slots
	localparam logic [4:0] RSI_TGT_RAM = 5'h0C;
	localparam logic [4:0] RSI_TGT_CTRL = 5'h0D;
	localparam logic [4:0] RSI_TGT_STAT = 5'h0E;
	localparam logic [4:0] RSI_TGT_ISR = 5'h0F;
	localparam logic [4:0] RSI_TGT_ICLR = 5'h10;
	localparam logic [4:0] RSI_TGT_IEN = 5'h11;
	localparam logic [4:0] RSI_TGT_NONE = 5'h1F;
	// interrupt status bits
	localparam int RSI_IRQ_W = 4;
	localparam int RSI_IRQ_PIN_RST = 0;
	localparam int RSI_IRQ_WDT_RST = 1;
	localparam int RSI_IRQ_WAKE = 2;
	localparam int RSI_IRQ_HALT = 3;
	localparam logic [1:0] RSI_RESP_OKAY = 2'h0;
	localparam logic [1:0] RSI_RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {RSI_RUN, RSI_SLEEP, RSI_IDLE} rsi_power_t;
endpackage : rsi_pkg

//--- design/rsi_reset_status.sv
/*
 reset status flags, register init on reset and wake-up, general purpose ram,
 with an AXI4-Lite slave for software access and one level interrupt.
 assumes aresetn is the power-on reset and all event inputs are one-cycle pulses
 synchronous to aclk.
*/
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module rsi_reset_status (
	// clock and power-on reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address and data
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// reset and wake events
	input wire logic ext_reset_pulse,
	input wire logic wdt_timeout_pulse,
	input wire logic watchdog_clear_instruction,
	input wire logic halt_instruction,
	input wire logic wake_event,
	// uart receive buffer load
	input wire logic uart_rx_load,
	input wire logic [7:0] uart_rx_byte,
	// status and control out
	output logic wdt_flag,
	output logic power_down_flag,
	output logic sleeping,
	output logic idling,
	output logic uart_send_enable,
	output logic uart_receive_enable,
	output logic spi_start,
	output logic irq
);
	import rsi_pkg::*;

	// maps a byte address to a register target
	function automatic logic [4:0] rsi_decode(input logic [11:0] addr);
		logic [4:0] tgt;
		tgt = RSI_TGT_NONE;
		for (int i = 0; i < RSI_NREG; i++)
		begin
			if (addr == (RSI_REG_BANK[i] | {4'h0, RSI_REG_OFS[i], 2'h0}))
				tgt = 5'(i);
		end
		if (addr[11:8] == RSI_BANK_RAM[11:8] && addr[1:0] == 2'h0 &&
			addr[7:2] >= RSI_OFS_GENERAL_PURPOSE_RAM)
			tgt = RSI_TGT_RAM;
		if (addr[11:8] == RSI_BANK_OWN[11:8] && addr[1:0] == 2'h0)
		begin
			unique case (addr[7:2])
				RSI_OFS_CTRL: tgt = RSI_TGT_CTRL;
				RSI_OFS_STAT: tgt = RSI_TGT_STAT;
				RSI_OFS_IRQ_STATUS: tgt = RSI_TGT_ISR;
				RSI_OFS_IRQ_CLEAR: tgt = RSI_TGT_ICLR;
				RSI_OFS_IRQ_ENABLE: tgt = RSI_TGT_IEN;
				default: tgt = RSI_TGT_NONE;
			endcase
		end
		return tgt;
	endfunction : rsi_decode

	logic aw_held_ff;
	logic w_held_ff;
	logic [11:0] aw_addr_ff;
	logic [31:0] w_data_ff;
	logic [3:0] w_strb_ff;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	logic rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rresp_ff;
	logic wr_fire;
	logic wr_lane0;
	logic [4:0] wr_tgt;
	logic [4:0] rd_tgt;
	logic [31:0] nxt_rdata;
	logic [7:0] reg_ff [RSI_NREG];
	logic [7:0] nxt_reg [RSI_NREG];
	logic [7:0] ram_ff [RSI_RAM_DEPTH];
	logic [5:0] wr_ram_idx;
	logic [5:0] rd_ram_idx;
	logic t_ff;
	logic p_ff;
	logic nxt_t;
	logic nxt_p;
	logic idle_sel_ff;
	rsi_power_t power_ff;
	rsi_power_t nxt_power;
	logic rst_evt;
	logic low_power;
	logic wake_any;
	logic [RSI_IRQ_W-1:0] isr_ff;
	logic [RSI_IRQ_W-1:0] ien_ff;
	logic [RSI_IRQ_W-1:0] irq_set;
	logic [RSI_IRQ_W-1:0] irq_clr;

	// write channel handshakes: address and data accepted in either order
	assign s_axi_awready = !aw_held_ff && !bvalid_ff;
	assign s_axi_wready = !w_held_ff && !bvalid_ff;
	assign s_axi_arready = !rvalid_ff;
	assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
	assign wr_lane0 = wr_fire && w_strb_ff[0];
	assign wr_tgt = rsi_decode(aw_addr_ff);
	assign rd_tgt = rsi_decode(s_axi_araddr);
	assign wr_ram_idx = aw_addr_ff[7:2] - RSI_OFS_GENERAL_PURPOSE_RAM;
	assign rd_ram_idx = s_axi_araddr[7:2] - RSI_OFS_GENERAL_PURPOSE_RAM;

	// write address and data holding
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_ff <= 1'b0;
			w_held_ff <= 1'b0;
			aw_addr_ff <= 12'h000;
			w_data_ff <= 32'h00000000;
			w_strb_ff <= 4'h0;
		end
		else if (wr_fire)
		begin
			aw_held_ff <= 1'b0;
			w_held_ff <= 1'b0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held_ff <= 1'b1;
				aw_addr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held_ff <= 1'b1;
				w_data_ff <= s_axi_wdata;
				w_strb_ff <= s_axi_wstrb;
			end
		end
	end

	// write response; unmapped targets and the own status and interrupt status registers answer with an error
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_ff <= 1'b0;
			bresp_ff <= RSI_RESP_OKAY;
		end
		else if (wr_fire)
		begin
			bvalid_ff <= 1'b1;
			bresp_ff <= (wr_tgt == RSI_TGT_NONE || wr_tgt == RSI_TGT_STAT ||
				wr_tgt == RSI_TGT_ISR) ? RSI_RESP_SLVERR : RSI_RESP_OKAY;
		end
		else if (s_axi_bready)
			bvalid_ff <= 1'b0;
	end

	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;

	// read data selection
	always_comb
	begin
		nxt_rdata = 32'h00000000;
		if (rd_tgt < RSI_TGT_RAM)
			nxt_rdata[7:0] = reg_ff[rd_tgt[3:0]];
		else if (rd_tgt == RSI_TGT_RAM)
			nxt_rdata[7:0] = ram_ff[rd_ram_idx];
		else if (rd_tgt == RSI_TGT_CTRL)
			nxt_rdata[0] = idle_sel_ff;
		else if (rd_tgt == RSI_TGT_STAT)
			nxt_rdata[3:0] = {idling, sleeping, p_ff, t_ff};
		else if (rd_tgt == RSI_TGT_ISR)
			nxt_rdata[RSI_IRQ_W-1:0] = isr_ff;
		else if (rd_tgt == RSI_TGT_IEN)
			nxt_rdata[RSI_IRQ_W-1:0] = ien_ff;
	end

	// read channel: data one cycle after address
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h00000000;
			rresp_ff <= RSI_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_ff <= 1'b1;
			rdata_ff <= nxt_rdata;
			rresp_ff <= (rd_tgt == RSI_TGT_NONE || rd_tgt == RSI_TGT_ICLR) ?
				RSI_RESP_SLVERR : RSI_RESP_OKAY;
		end
		else if (s_axi_rready)
			rvalid_ff <= 1'b0;
	end

	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;

	// event qualification
	assign rst_evt = ext_reset_pulse || wdt_timeout_pulse;
	assign low_power = (power_ff != RSI_RUN);
	assign wake_any = low_power && (wake_event || rst_evt);

	// low-power mode entered by halt, left by any wake source
	always_comb
	begin
		nxt_power = power_ff;
		unique case (power_ff)
			RSI_RUN:
				if (halt_instruction && !rst_evt)
					nxt_power = idle_sel_ff ? RSI_IDLE : RSI_SLEEP;
			RSI_SLEEP, RSI_IDLE:
				if (wake_event || rst_evt)
					nxt_power = RSI_RUN;
			default: nxt_power = RSI_RUN;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			power_ff <= RSI_RUN;
		else
			power_ff <= nxt_power;
	end

	assign sleeping = (power_ff == RSI_SLEEP);
	assign idling = (power_ff == RSI_IDLE);

	// time-out and power-down flags
	always_comb
	begin
		nxt_t = t_ff;
		nxt_p = p_ff;
		if (wdt_timeout_pulse)
			nxt_t = 1'b0;
		else if (ext_reset_pulse)
			nxt_t = t_ff;
		else if (watchdog_clear_instruction)
		begin
			nxt_t = 1'b1;
			nxt_p = 1'b1;
		end
		else if (halt_instruction && !low_power)
		begin
			nxt_t = 1'b1;
			nxt_p = 1'b0;
		end
		else if (wake_event)
			nxt_t = t_ff;
	end

	// power-on reset overrides every other event in the same cycle
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			t_ff <= 1'b1;
			p_ff <= 1'b1;
		end
		else
		begin
			t_ff <= nxt_t;
			p_ff <= nxt_p;
		end
	end

	assign wdt_flag = t_ff;
	assign power_down_flag = p_ff;

	// bank registers: reset masks, wake clears, software writes
	always_comb
	begin
		for (int i = 0; i < RSI_NREG; i++)
		begin
			nxt_reg[i] = reg_ff[i];
			if (rst_evt)
				nxt_reg[i] = (reg_ff[i] & RSI_RST_KEEP[i]) | RSI_RST_SET[i];
			else if (wr_lane0 && wr_tgt == 5'(i))
				nxt_reg[i] = (reg_ff[i] & ~RSI_WR[i]) | (w_data_ff[7:0] & RSI_WR[i]);
			else if (uart_rx_load && i == RSI_SLOT_UART_RECEIVE_BUFFER)
				nxt_reg[i] = uart_rx_byte;
			if (wake_any)
			begin
				nxt_reg[i] = nxt_reg[i] & ~RSI_WAKE_CLR[i];
				if (sleeping)
					nxt_reg[i] = nxt_reg[i] & ~RSI_SLEEP_CLR[i];
			end
			nxt_reg[i] = nxt_reg[i] & RSI_IMP[i];
		end
	end

	always_ff @(posedge aclk)
	begin
		for (int i = 0; i < RSI_NREG; i++)
		begin
			if (!aresetn)
				reg_ff[i] <= RSI_POR[i];
			else
				reg_ff[i] <= nxt_reg[i];
		end
	end

	assign uart_send_enable = reg_ff[RSI_SLOT_UART_CONTROL_ONE][0];
	assign uart_receive_enable = reg_ff[RSI_SLOT_UART_CONTROL_ONE + 2][0];
	assign spi_start = reg_ff[RSI_SLOT_SERIAL_PERIPH_CONTROL_TWO][7];

	// general purpose ram: no reset, kept through every reset including power-on
	always_ff @(posedge aclk)
	begin
		if (wr_lane0 && wr_tgt == RSI_TGT_RAM)
			ram_ff[wr_ram_idx] <= w_data_ff[7:0];
	end

	// own control register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			idle_sel_ff <= 1'b0;
		else if (wr_lane0 && wr_tgt == RSI_TGT_CTRL)
			idle_sel_ff <= w_data_ff[0];
	end

	// interrupt events and write-one-to-clear
	always_comb
	begin
		irq_set = '0;
		irq_set[RSI_IRQ_PIN_RST] = ext_reset_pulse;
		irq_set[RSI_IRQ_WDT_RST] = wdt_timeout_pulse;
		irq_set[RSI_IRQ_WAKE] = wake_any;
		irq_set[RSI_IRQ_HALT] = (power_ff == RSI_RUN) && (nxt_power != RSI_RUN);
		irq_clr = '0;
		if (wr_lane0 && wr_tgt == RSI_TGT_ICLR)
			irq_clr = w_data_ff[RSI_IRQ_W-1:0];
	end

	// sticky status: a set in the clearing cycle wins
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			isr_ff <= '0;
		else
			isr_ff <= (isr_ff & ~irq_clr) | irq_set;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ien_ff <= '0;
		else if (wr_lane0 && wr_tgt == RSI_TGT_IEN)
			ien_ff <= w_data_ff[RSI_IRQ_W-1:0];
	end

	assign irq = |(isr_ff & ien_ff);
endmodule : rsi_reset_status

`default_nettype wire

//--- verif/rsi_reset_status_props.sv
/*
 checker for the reset status block: flag updates, register clears, read answer.
 assumes event inputs are one-cycle pulses on aclk; bound to the top module.
*/
`timescale 1ns/1ps
`default_nettype none
module rsi_reset_status_props (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// events
	input wire logic ext_reset_pulse,
	input wire logic wdt_timeout_pulse,
	input wire logic watchdog_clear_instruction,
	input wire logic halt_instruction,
	input wire logic wake_event,
	// read address and answer
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	// status out
	input wire logic wdt_flag,
	input wire logic power_down_flag,
	input wire logic sleeping,
	input wire logic idling,
	input wire logic uart_send_enable,
	input wire logic uart_receive_enable,
	input wire logic spi_start
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// helper terms
	wire logic low_pwr = sleeping || idling;
	wire logic rst_ev = ext_reset_pulse || wdt_timeout_pulse;
	// wake steps: low power and a waking event in the same cycle
	sequence s_wake;
		low_pwr && (wake_event || rst_ev);
	endsequence
	sequence s_kept;
		$stable(wdt_flag) && $stable(power_down_flag);
	endsequence
	// power-on wins over everything, so the reset itself is not a disable here
	property p_por;
		disable iff (1'b0) !aresetn |=> wdt_flag && power_down_flag;
	endproperty
	property p_pin;
		ext_reset_pulse && !wdt_timeout_pulse |=> s_kept;
	endproperty
	property p_wdt;
		wdt_timeout_pulse |=> !wdt_flag && $stable(power_down_flag);
	endproperty
	property p_wdc;
		watchdog_clear_instruction && !rst_ev |=> wdt_flag && power_down_flag;
	endproperty
	property p_halt;
		halt_instruction && !low_pwr && !rst_ev && !watchdog_clear_instruction
			|=> wdt_flag && !power_down_flag && low_pwr;
	endproperty
	property p_wake;
		wake_event && low_pwr && !rst_ev && !watchdog_clear_instruction |=> s_kept ##0 !low_pwr;
	endproperty
	property p_rst_clr;
		rst_ev |=> !uart_send_enable && !uart_receive_enable && !spi_start;
	endproperty
	property p_wake_clr;
		s_wake |=> !uart_send_enable && !uart_receive_enable;
	endproperty
	property p_sleep_clr;
		sleeping && (wake_event || rst_ev) |=> !spi_start;
	endproperty
	property p_rd;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_por: assert property (p_por) else $error("flags not set by power-on");
	a_pin: assert property (p_pin) else $error("pin reset changed flags");
	a_wdt: assert property (p_wdt) else $error("watchdog flag update wrong");
	a_wdc: assert property (p_wdc) else $error("clear instruction flags wrong");
	a_halt: assert property (p_halt) else $error("halt flags wrong");
	a_wake: assert property (p_wake) else $error("plain wake changed flags");
	a_rst_clr: assert property (p_rst_clr) else $error("reset left enables set");
	a_wake_clr: assert property (p_wake_clr) else $error("wake left enables set");
	a_sleep_clr: assert property (p_sleep_clr) else $error("sleep wake kept start");
	a_rd: assert property (p_rd) else $error("read answer late");
endmodule : rsi_reset_status_props
bind rsi_reset_status rsi_reset_status_props u_props (.aclk, .aresetn, .ext_reset_pulse,
	.wdt_timeout_pulse, .watchdog_clear_instruction, .halt_instruction, .wake_event,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .wdt_flag, .power_down_flag, .sleeping,
	.idling, .uart_send_enable, .uart_receive_enable, .spi_start);
`default_nettype wire

//--- verif/testbench.sv
/*
 testbench for the reset status block: bus tasks, event pulses, expected values.
 assumes a 20 MHz aclk and a one-word AXI4-Lite map as set out in the package.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import rsi_pkg::*;
	// register byte addresses
	localparam logic [11:0] ad_uart_c1 = 12'h014, ad_uart_st = 12'h01C, ad_uart_rx = 12'h020;
	localparam logic [11:0] ad_spi_c1 = 12'h114, ad_spi_c2 = 12'h118, ad_pull_h1 = 12'h128;
	localparam logic [11:0] ad_ram = 12'h240, ad_ctrl = 12'h300, ad_stat = 12'h304;
	localparam logic [11:0] ad_isr = 12'h308, ad_iclr = 12'h30C, ad_ien = 12'h310;
	// drives
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h000;
	logic [11:0] s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	// response readies stay high, so back-to-back calls never toggle them
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b1, uart_rx_load = 1'b0;
	logic ext_reset_pulse = 1'b0, wdt_timeout_pulse = 1'b0, watchdog_clear_instruction = 1'b0;
	logic halt_instruction = 1'b0, wake_event = 1'b0;
	logic [7:0] uart_rx_byte = 8'h00;
	// observed
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic wdt_flag, power_down_flag, sleeping, idling;
	logic uart_send_enable, uart_receive_enable, spi_start, irq;
	int fail_count = 0;
	int num_checks = 0;
	// clock
	always #25 aclk = ~aclk;
	rsi_reset_status u_rsi_reset_status (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_reset_pulse,
		.wdt_timeout_pulse, .watchdog_clear_instruction, .halt_instruction, .wake_event,
		.uart_rx_load, .uart_rx_byte, .wdt_flag, .power_down_flag, .sleeping, .idling,
		.uart_send_enable, .uart_receive_enable, .spi_start, .irq);
	// verdict and end of run
	task automatic conclude;
		if (fail_count == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : conclude
	// compare one value
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// one write; each channel released when taken
	task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
		logic aw_go, w_go, b_go;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		b_go = 1'b0;
		for (int n = 0; n < 40 && !b_go; n++)
		begin
			@(negedge aclk);
			aw_go = s_axi_awvalid && s_axi_awready;
			w_go = s_axi_wvalid && s_axi_wready;
			b_go = (s_axi_bvalid === 1'b1);
			if (b_go)
				chk({30'h0, s_axi_bresp}, {30'h0, er});
			@(posedge aclk);
			if (aw_go)
				s_axi_awvalid <= 1'b0;
			if (w_go)
				s_axi_wvalid <= 1'b0;
		end
		if (!b_go)
		begin
			fail_count++;
			conclude();
		end
	endtask : wr
	// one read with expected data and response
	task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er = 2'h0);
		logic ar_go, r_go;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		r_go = 1'b0;
		for (int n = 0; n < 40 && !r_go; n++)
		begin
			@(negedge aclk);
			ar_go = s_axi_arvalid && s_axi_arready;
			r_go = (s_axi_rvalid === 1'b1);
			if (r_go)
			begin
				chk(s_axi_rdata, {24'h0, d});
				chk({30'h0, s_axi_rresp}, {30'h0, er});
			end
			@(posedge aclk);
			if (ar_go)
				s_axi_arvalid <= 1'b0;
		end
		if (!r_go)
		begin
			fail_count++;
			conclude();
		end
	endtask : rd
	// event pulse, bits are pin reset, watchdog, clear, halt, wake
	task automatic ev(input logic [4:0] m);
		{ext_reset_pulse, wdt_timeout_pulse, watchdog_clear_instruction, halt_instruction,
			wake_event} <= m;
		@(posedge aclk);
		{ext_reset_pulse, wdt_timeout_pulse, watchdog_clear_instruction, halt_instruction,
			wake_event} <= 5'h00;
		@(posedge aclk);
	endtask : ev
	// pins irq, sleeping, power-down flag, time-out flag
	task automatic pins(input logic [3:0] e);
		@(negedge aclk);
		chk({28'h0, irq, sleeping, power_down_flag, wdt_flag}, {28'h0, e});
		@(posedge aclk);
	endtask : pins
	// pins spi start, uart receive enable, uart send enable
	task automatic outs(input logic [2:0] e);
		@(negedge aclk);
		chk({29'h0, spi_start, uart_receive_enable, uart_send_enable}, {29'h0, e});
		@(posedge aclk);
	endtask : outs
	// main sequence; status reads as {idling, sleeping, power-down, time-out}
	initial
	begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(ad_stat, 8'h03);
		rd(ad_pull_h1, 8'h3F);
		rd(ad_pull_h1 + 12'h004, 8'h3F);
		rd(ad_pull_h1 + 12'h008, 8'h0F);
		rd(ad_pull_h1 + 12'h00C, 8'h0F);
		rd(ad_spi_c2, 8'h00);
		// watchdog in run, interrupt masked, enabled, then cleared
		ev(5'h08);
		rd(ad_stat, 8'h02);
		pins(4'h2);
		rd(ad_isr, 8'h02);
		wr(ad_ien, 8'h02, 2'h0);
		pins(4'hA);
		wr(ad_iclr, 8'h02, 2'h0);
		rd(ad_isr, 8'h00);
		pins(4'h2);
		ev(5'h04);
		rd(ad_stat, 8'h03);
		// sleep, then plain wake
		ev(5'h02);
		rd(ad_stat, 8'h05);
		wr(ad_uart_c1, 8'hFF, 2'h0);
		wr(ad_spi_c2, 8'h87, 2'h0);
		outs(3'h5);
		ev(5'h01);
		outs(3'h0);
		rd(ad_stat, 8'h01);
		rd(ad_uart_c1, 8'hBE);
		rd(ad_spi_c2, 8'h07);
		// idle, then watchdog wake
		wr(ad_ctrl, 8'h01, 2'h0);
		wr(ad_uart_c1, 8'hFF, 2'h0);
		ev(5'h02);
		rd(ad_stat, 8'h09);
		ev(5'h08);
		rd(ad_stat, 8'h00);
		rd(ad_uart_c1, 8'hFC);
		// pin reset in run
		wr(ad_uart_st, 8'hFF, 2'h0);
		wr(ad_uart_c1, 8'hFF, 2'h0);
		wr(ad_spi_c1, 8'hFF, 2'h0);
		wr(ad_spi_c2, 8'h87, 2'h0);
		wr(ad_pull_h1, 8'h00, 2'h0);
		wr(ad_ram, 8'h5A, 2'h0);
		uart_rx_byte <= 8'hA5;
		uart_rx_load <= 1'b1;
		@(posedge aclk);
		uart_rx_load <= 1'b0;
		ev(5'h10);
		rd(ad_stat, 8'h00);
		rd(ad_uart_c1, 8'hFC);
		rd(ad_uart_st, 8'hE0);
		rd(ad_spi_c1, 8'hFE);
		rd(ad_spi_c2, 8'h06);
		rd(ad_pull_h1, 8'h3F);
		rd(ad_uart_rx, 8'hA5);
		rd(ad_ram, 8'h5A);
		// lane 0 strobe off: answered, nothing written
		s_axi_wstrb <= 4'hE;
		wr(ad_ram, 8'hFF, 2'h0);
		s_axi_wstrb <= 4'hF;
		rd(ad_ram, 8'h5A);
		// pin reset wakes from sleep
		wr(ad_ctrl, 8'h00, 2'h0);
		ev(5'h02);
		rd(ad_stat, 8'h05);
		ev(5'h10);
		rd(ad_stat, 8'h01);
		// refused accesses
		rd(12'h3FC, 8'h00, 2'h2);
		wr(ad_stat, 8'hFF, 2'h2);
		// power-on together with pin and watchdog resets
		aresetn <= 1'b0;
		ev(5'h18);
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(ad_stat, 8'h03);
		conclude();
	end
endmodule : testbench
`default_nettype wire
